//--- verilog/chd_top.sv
/*
  chd_top: five channel clock dividers with register file.
  dividers 0..2 single stage with coarse delay, 3..4 two cascaded stages.
  assumes: sys_clk edges are the divider input cycles; src_clk_pin is
  the distribution source level, slower than sys_clk, used for bypass.
*/
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module chd_top (
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic ce,
  // register port
  input wire logic [chd_pkg::CHD_AW-1:0] reg_addr,
  input wire logic [chd_pkg::CHD_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [chd_pkg::CHD_DW-1:0] reg_rdata,
  // distribution source pin
  input wire logic src_clk_pin,
  // channel outputs
  output logic [2:0] ch_out,
  output logic ch3_out_a,
  output logic ch3_out_b,
  output logic ch4_out_a,
  output logic ch4_out_b
);
  import chd_pkg::*;

  // ----------------------------------------------------------------
  // source synchroniser
  // ----------------------------------------------------------------
  logic src_m_q, src_s_q, src_d_q; // meta, stable, delayed
  logic src_rise;

  // first flop feeds only the second; the third copy only delays
  // the stable level so that a rising edge can be seen
  // limitation: the source must stay below half of sys_clk
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      src_m_q <= 1'b0;
      src_s_q <= 1'b0;
      src_d_q <= 1'b0;
    end else if (ce) begin
      src_m_q <= src_clk_pin;
      src_s_q <= src_m_q;
      src_d_q <= src_s_q;
    end
  end
  assign src_rise = src_s_q & ~src_d_q;

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [CHD_DW-1:0] reg_q [CHD_NSLOT]; // storage slots
  logic [CHD_NSLOT-1:0] hit;            // slot decode
  logic [CHD_DW-1:0] rd_mux;
  logic [CHD_DW-1:0] rdata_q;
  logic [CHD_DW-1:0] status;
  logic any_hit, hit_sync, hit_status;

  // address decode, one compare per slot
  for (genvar i = 0; i < CHD_NSLOT; i++) begin : g_dec
    assign hit[i] = (reg_addr == CHD_SLOT_ADDR[i]);
  end
  assign hit_sync = (reg_addr == CHD_OFF_SYNC);
  assign hit_status = (reg_addr == CHD_OFF_STATUS);
  assign any_hit = (|hit) | hit_sync | hit_status;

  // one-hot select; unmapped and sync address read as zero
  always_comb begin
    rd_mux = hit_status ? status : '0;
    for (int i = 0; i < CHD_NSLOT; i++) begin
      if (hit[i]) rd_mux = reg_q[i];
    end
  end

  // writes to unmapped or status places touch no slot
  // reset value keeps correction on, B outputs off
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < CHD_NSLOT; i++) reg_q[i] <= CHD_RST_REG;
    end else if (ce && reg_wr) begin
      for (int i = 0; i < CHD_NSLOT; i++) begin
        if (hit[i]) reg_q[i] <= reg_wdata;
      end
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) rdata_q <= '0;
    else if (ce) rdata_q <= reg_rd ? rd_mux : '0;
  end
  assign reg_rdata = rdata_q;

  // ----------------------------------------------------------------
  // sync: automatic once after reset, then on software request
  // ----------------------------------------------------------------
  logic boot_q, sync_q, synced_q;

  // boot_q fires one sync so that dividers leave reset running
  // synced_q is sticky and shows in the status byte
  // offsets wait for a sync
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      boot_q <= 1'b1;
      sync_q <= 1'b0;
      synced_q <= 1'b0;
    end else if (ce) begin
      boot_q <= 1'b0;
      sync_q <= boot_q | (reg_wr & hit_sync & reg_wdata[CHD_SYNC_BIT]);
      synced_q <= synced_q | sync_q;
    end
  end

  // ----------------------------------------------------------------
  // bypass duty corrector on the source
  // ----------------------------------------------------------------
  logic [CHD_PERW-1:0] per_cnt_q, per_q, hcnt_q;
  logic corr_q, corr_neg_q, src_corr;

  // measure source period, rebuild a half-period high pulse
  // trade-off: the rebuilt edges fall on sys_clk edges, so the
  // corrected output trails the source by the synchroniser delay
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      per_cnt_q <= '0;
      per_q <= '0;
      hcnt_q <= '0;
      corr_q <= 1'b0;
    end else if (ce) begin
      if (src_rise) begin
        per_q <= per_cnt_q;
        per_cnt_q <= CHD_PERW'(1);
        hcnt_q <= CHD_PERW'(1);
        corr_q <= 1'b1;
      end else begin
        // saturate so a stopped source cannot wrap
        if (per_cnt_q != '1) per_cnt_q <= per_cnt_q + CHD_PERW'(1);
        if (hcnt_q >= (per_q >> 1)) corr_q <= 1'b0;
        else hcnt_q <= hcnt_q + CHD_PERW'(1);
      end
    end
  end

  // odd period gets half a cycle more high
  always_ff @(negedge sys_clk or negedge rstn) begin
    if (!rstn) corr_neg_q <= 1'b0;
    else if (ce) corr_neg_q <= corr_q & per_q[0];
  end
  assign src_corr = corr_q | corr_neg_q;

  // ----------------------------------------------------------------
  // dividers 0..2
  // ----------------------------------------------------------------
  logic [2:0] d_out;

  for (genvar c = 0; c < 3; c++) begin : g_pecl
    localparam int SL = CHD_SL_D0CNT + 3 * c;
    // low count high nibble, high count low nibble
    wire [CHD_CW-1:0] low_cnt = reg_q[SL][CHD_LOW_LSB +: CHD_CW];
    wire [CHD_CW-1:0] high_cnt = reg_q[SL][CHD_HIGH_LSB +: CHD_CW];
    wire bypass = reg_q[SL+1][CHD_BYP_BIT];
    wire start_high = reg_q[SL+1][CHD_SH_BIT];
    wire [CHD_CW-1:0] coarse_delay_field = reg_q[SL+1][CHD_PO_LSB +: CHD_CW];
    wire dcc_on = ~reg_q[SL+2][CHD_DUTY_CORRECTION_DISABLE_BIT];
    wire [CHD_DLW-1:0] delay;
    // start-high carries weight M+1 over the offset
    // start-high: offset plus low count plus one
    assign delay = start_high ?
      CHD_DLW'({1'b0, coarse_delay_field} + {1'b0, low_cnt} + 5'h01) :
      CHD_DLW'(coarse_delay_field);
    // the stage takes counts and delay only at sync; bypass and
    // the correction select on the bypass path act at once
    // counter divides by N+M+2
    chd_stage #(.CW(CHD_CW), .DLW(CHD_DLW)) u_div (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .ce(ce),
      .sync(sync_q),
      .adv(~bypass),
      .low_cnt(low_cnt),
      .high_cnt(high_cnt),
      .dcc_en(dcc_on),
      .delay(delay),
      .q_out(d_out[c]),
      .rise_out()
    );
    // bypass passes the source, counter held
    // uncorrected bypass keeps the source duty cycle
    assign ch_out[c] = bypass ? (dcc_on ? src_corr : src_s_q) : d_out[c];
  end

  // ----------------------------------------------------------------
  // dividers 3..4, two cascaded stages
  // ----------------------------------------------------------------
  logic [1:0] cas_out;

  for (genvar c = 0; c < 2; c++) begin : g_lvds
    localparam int SL = (c == 0) ? CHD_SL_D3S1 : CHD_SL_D4S1;
    wire byp1 = reg_q[SL+2][CHD_S1_BYP_BIT];
    wire byp2 = reg_q[SL+2][CHD_S2_BYP_BIT];
    // one disable bit covers both stages
    wire dcc_on = ~reg_q[SL+3][CHD_DUTY_CORRECTION_DISABLE_BIT];
    wire s1_q, s1_rise, s2_q;
    // first stage counts every input cycle
    chd_stage #(.CW(CHD_CW), .DLW(CHD_DLW)) u_st1 (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .ce(ce),
      .sync(sync_q),
      .adv(~byp1),
      .low_cnt(reg_q[SL][CHD_LOW_LSB +: CHD_CW]),
      .high_cnt(reg_q[SL][CHD_HIGH_LSB +: CHD_CW]),
      .dcc_en(dcc_on),
      .delay('0),
      .q_out(s1_q),
      .rise_out(s1_rise)
    );
    // stage two advances once per stage one period; its correction
    // adds half a sys_clk only, not half a stage one period
    // second stage counts first stage periods
    chd_stage #(.CW(CHD_CW), .DLW(CHD_DLW)) u_st2 (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .ce(ce),
      .sync(sync_q),
      .adv(s1_rise & ~byp2),
      .low_cnt(reg_q[SL+1][CHD_LOW_LSB +: CHD_CW]),
      .high_cnt(reg_q[SL+1][CHD_HIGH_LSB +: CHD_CW]),
      .dcc_en(dcc_on),
      .delay('0),
      .q_out(s2_q),
      .rise_out()
    );
    // both bypassed: source; second bypassed: stage one
    // first-only bypass is not a supported setting
    assign cas_out[c] = byp1 ? (dcc_on ? src_corr : src_s_q) :
                        (byp2 ? s1_q : s2_q);
  end

  // B outputs gated by the enable register
  assign ch3_out_a = cas_out[0];
  assign ch4_out_a = cas_out[1];
  assign ch3_out_b = cas_out[0] & reg_q[CHD_SL_BOUT][0];
  assign ch4_out_b = cas_out[1] & reg_q[CHD_SL_BOUT][1];

  // live output levels and the first-sync flag
  assign status = {2'b00, synced_q, cas_out, ch_out};

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // register port, reset defaults, boot sync and bypass paths
  chk_read_latency: assert property (@(posedge sys_clk) disable iff (!rstn || !ce)
    (reg_rd && hit[CHD_SL_D0CNT]) |=> reg_rdata == $past(reg_q[CHD_SL_D0CNT]))
    else $error("register read not returned next cycle");
  chk_unmapped_zero: assert property (@(posedge sys_clk) disable iff (!rstn || !ce)
    (reg_rd && !any_hit) |=> reg_rdata == '0)
    else $error("unmapped read not zero");
  chk_dcc_default: assert property (@(posedge sys_clk) disable iff (!rstn)
    boot_q |-> (reg_q[2][CHD_DUTY_CORRECTION_DISABLE_BIT] == 1'b0 && reg_q[CHD_SL_D3DCC] == '0))
    else $error("correction not enabled after reset");
  chk_b_default: assert property (@(posedge sys_clk) disable iff (!rstn)
    !reg_q[CHD_SL_BOUT][0] |-> !ch3_out_b)
    else $error("B output active while disabled");
  chk_boot_sync: assert property (@(posedge sys_clk) disable iff (!rstn || !ce)
    boot_q |=> (sync_q ##1 synced_q))
    else $error("no automatic sync after reset");
  chk_bypass_pass: assert property (@(posedge sys_clk) disable iff (!rstn)
    (reg_q[1][CHD_BYP_BIT] && reg_q[2][CHD_DUTY_CORRECTION_DISABLE_BIT]) |-> ch_out[0] == src_s_q)
    else $error("bypassed divider does not follow source");
  chk_single_stage: assert property (@(posedge sys_clk) disable iff (!rstn)
    (!reg_q[CHD_SL_D3BYP][CHD_S1_BYP_BIT] && reg_q[CHD_SL_D3BYP][CHD_S2_BYP_BIT])
      |-> ch3_out_a == g_lvds[0].s1_q)
    else $error("second-stage bypass not using first stage");
  chk_div4_single: assert property (@(posedge sys_clk) disable iff (!rstn)
    (!reg_q[CHD_SL_D4S1+2][CHD_S1_BYP_BIT] && reg_q[CHD_SL_D4S1+2][CHD_S2_BYP_BIT])
      |-> ch4_out_a == g_lvds[1].s1_q)
    else $error("divider 4 second-stage bypass not using first stage");
  chk_both_bypass: assert property (@(posedge sys_clk) disable iff (!rstn)
    (reg_q[CHD_SL_D3BYP][CHD_S1_BYP_BIT] && reg_q[CHD_SL_D3DCC][CHD_DUTY_CORRECTION_DISABLE_BIT])
      |-> ch3_out_a == src_s_q)
    else $error("fully bypassed divider 3 does not follow source");

  // B outputs, sync request and register port timing
  chk_b4_default: assert property (@(posedge sys_clk) disable iff (!rstn)
    !reg_q[CHD_SL_BOUT][1] |-> !ch4_out_b)
    else $error("divider 4 B output active while disabled");
  chk_b3_follow: assert property (@(posedge sys_clk) disable iff (!rstn)
    reg_q[CHD_SL_BOUT][0] |-> ch3_out_b == ch3_out_a)
    else $error("enabled B output does not follow A");
  chk_sync_req: assert property (@(posedge sys_clk) disable iff (!rstn || !ce)
    (reg_wr && hit_sync && reg_wdata[CHD_SYNC_BIT]) |=> sync_q)
    else $error("sync request not passed to dividers");
  chk_rdata_idle: assert property (@(posedge sys_clk) disable iff (!rstn || !ce)
    !reg_rd |=> reg_rdata == '0)
    else $error("read data not cleared after one cycle");
  chk_wr_lands: assert property (@(posedge sys_clk) disable iff (!rstn || !ce)
    (reg_wr && hit[CHD_SL_D0CNT]) |=> reg_q[CHD_SL_D0CNT] == $past(reg_wdata))
    else $error("register write did not land");
endmodule // chd_top
`default_nettype wire

//--- verilog/chd_pkg.sv
/*
  chd_pkg: register map, field positions, reset values and state type
  for the channel clock divider block.
  assumes: 9-bit register addresses, 8-bit register data.
*/
`default_nettype none
package chd_pkg;
  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int CHD_AW = 9;  // register address width
  localparam int CHD_DW = 8;  // register data width
  localparam int CHD_CW = 4;  // low / high count width
  localparam int CHD_DLW = 5; // delay count width
  localparam int CHD_PERW = 8; // source period counter width
  // ----------------------------------------------------------------
  // register slots and their byte addresses
  // ----------------------------------------------------------------
  localparam int CHD_NSLOT = 18;
  localparam int CHD_SL_D0CNT = 0; // dividers 0..2: divider n uses slots 3n..3n+2
  localparam int CHD_SL_D3S1 = 9;
  localparam int CHD_SL_D3S2 = 10;
  localparam int CHD_SL_D3BYP = 11;
  localparam int CHD_SL_D3DCC = 12;
  localparam int CHD_SL_D4S1 = 13; // divider 4 slots follow divider 3
  localparam int CHD_SL_BOUT = 17;
  localparam logic [8:0] CHD_SLOT_ADDR [CHD_NSLOT] = '{
    9'h190, 9'h191, 9'h192, 9'h193, 9'h194, 9'h195,
    9'h196, 9'h197, 9'h198, 9'h199, 9'h19b, 9'h19c,
    9'h19d, 9'h19e, 9'h1a0, 9'h1a1, 9'h1a2, 9'h1a4};
  localparam logic [8:0] CHD_OFF_SYNC = 9'h1a5;   // write bit 0: sync
  localparam logic [8:0] CHD_OFF_STATUS = 9'h1a6; // read only
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CHD_LOW_LSB = 4;   // low count bits 7:4
  localparam int CHD_HIGH_LSB = 0;  // high count bits 3:0
  localparam int CHD_BYP_BIT = 7;   // single stage bypass
  localparam int CHD_SH_BIT = 4;    // initial_level_high
  localparam int CHD_PO_LSB = 0;    // coarse_delay_field bits 3:0
  localparam int CHD_S1_BYP_BIT = 4;
  localparam int CHD_S2_BYP_BIT = 5;
  localparam int CHD_DUTY_CORRECTION_DISABLE_BIT = 0; // duty_correction_disable
  localparam int CHD_SYNC_BIT = 0;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CHD_RST_REG = 8'h00; // correction on, B off
  // ----------------------------------------------------------------
  // divider stage states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {CHD_ST_WAIT, CHD_ST_HIGH, CHD_ST_LOW} chd_state_t;
endpackage
`default_nettype wire

//--- verilog/chd_stage.sv
/*
  chd_stage: one programmable divider stage with start delay and
  half-cycle duty correction.
  assumes: adv marks one divider input cycle; settings are taken only
  on the sync pulse.
*/
`timescale 1ns/1ps
`default_nettype none
module chd_stage #(
  parameter int CW = chd_pkg::CHD_CW,
  parameter int DLW = chd_pkg::CHD_DLW
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic ce,
  // control
  input wire logic sync,
  input wire logic adv,
  input wire logic [CW-1:0] low_cnt,
  input wire logic [CW-1:0] high_cnt,
  input wire logic dcc_en,
  input wire logic [DLW-1:0] delay,
  // divided output
  output logic q_out,
  output logic rise_out
);
  import chd_pkg::*;

  if (CW < 2 || DLW < CW) begin : g_bad
    $error("chd_stage: count or delay width too small");
  end

  // active copies, loaded only at sync
  logic [CW-1:0] low_q, high_q, cnt_q, cnt_d;
  logic [DLW-1:0] dly_q, dly_d;
  logic stretch_q; // odd split with correction on
  logic neg_q;     // falling-edge extension of the high phase
  logic rise_q;
  chd_state_t st_q, st_d;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    dly_d = dly_q;
    if (sync) begin
      dly_d = delay;
      cnt_d = '0;
      st_d = (delay == '0) ? CHD_ST_HIGH : CHD_ST_WAIT;
    end else if (adv) begin
      unique case (st_q)
        // delay counted in input rising edges
        CHD_ST_WAIT: begin
          if (dly_q == DLW'(1)) st_d = CHD_ST_HIGH;
          if (dly_q != '0) dly_d = dly_q - DLW'(1);
        end
        CHD_ST_HIGH: begin
          cnt_d = (cnt_q == high_q) ? '0 : cnt_q + CW'(1);
          if (cnt_q == high_q) st_d = CHD_ST_LOW;
        end
        CHD_ST_LOW: begin
          cnt_d = (cnt_q == low_q) ? '0 : cnt_q + CW'(1);
          if (cnt_q == low_q) st_d = CHD_ST_HIGH;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state registers; held until the first sync
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= CHD_ST_WAIT;
      cnt_q <= '0;
      dly_q <= '0;
      low_q <= '0;
      high_q <= '0;
      stretch_q <= 1'b0;
      rise_q <= 1'b0;
    end else if (ce) begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      dly_q <= dly_d;
      rise_q <= (st_d == CHD_ST_HIGH) && (st_q != CHD_ST_HIGH);
      if (sync) begin
        low_q <= low_cnt;
        high_q <= high_cnt;
        // correction only meaningful for M = N + 1
        stretch_q <= dcc_en && (low_cnt == CW'(high_cnt + CW'(1)));
      end
    end
  end

  // half-cycle extension gives 50% on odd splits
  // limitation: exact only when adv is high every cycle
  always_ff @(negedge sys_clk or negedge rstn) begin
    if (!rstn) neg_q <= 1'b0;
    else if (ce) neg_q <= stretch_q && (st_q == CHD_ST_HIGH);
  end

  assign q_out = (st_q == CHD_ST_HIGH) | neg_q;
  assign rise_out = rise_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_high_end: assert property (@(posedge sys_clk) disable iff (!rstn || !ce)
    (st_q == CHD_ST_HIGH && adv && !sync && cnt_q == high_q) |=> st_q == CHD_ST_LOW)
    else $error("high phase did not end after count");
  chk_low_end: assert property (@(posedge sys_clk) disable iff (!rstn || !ce)
    (st_q == CHD_ST_LOW && adv && !sync && cnt_q == low_q) |=> st_q == CHD_ST_HIGH)
    else $error("low phase did not end after count");
  chk_sync_start: assert property (@(posedge sys_clk) disable iff (!rstn || !ce)
    (sync && delay == '0) |=> (st_q == CHD_ST_HIGH && cnt_q == '0))
    else $error("undelayed sync did not start high");
  chk_delay_load: assert property (@(posedge sys_clk) disable iff (!rstn || !ce)
    (sync && delay != '0) |=> (st_q == CHD_ST_WAIT && dly_q == $past(delay)))
    else $error("delay not loaded at sync");
endmodule // chd_stage
`default_nettype wire

//--- tb/tb_top.sv
/*
  tb_top: self-checking bench for the channel clock divider top.
  assumes: chd_top from verilog/, register port with one-cycle strobes,
  output timing measured in picoseconds at a 4 ns sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import chd_pkg::*;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic [CHD_AW-1:0] reg_addr = '0;
  logic [CHD_DW-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [CHD_DW-1:0] reg_rdata;
  logic src_clk_pin = 1'b0; // source level, cycles set by src_hi/src_lo
  logic [2:0] ch_out;
  logic ch3_out_a, ch3_out_b, ch4_out_a, ch4_out_b;
  wire [6:0] outs = {ch4_out_b, ch4_out_a, ch3_out_b, ch3_out_a, ch_out};
  int src_hi = 2;
  int src_lo = 2;
  int error_cnt = 0;
  int checked = 0;
  int cyc = 0;
  // ----------------------------------------------------------------
  // clock, source level and hang guard
  // ----------------------------------------------------------------
  always #2 sys_clk = ~sys_clk;
  // source toggles on sys_clk edges so its duty is exact in cycles
  always begin
    src_clk_pin <= 1'b1;
    repeat (src_hi) @(posedge sys_clk);
    src_clk_pin <= 1'b0;
    repeat (src_lo) @(posedge sys_clk);
  end
  // cut a hang short well above the expected run length
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      conclude();
    end
  end
  chd_top chd_top_inst (
    .sys_clk(sys_clk), .rstn(rstn), .ce(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_clk_pin(src_clk_pin),
    .ch_out(ch_out), .ch3_out_a(ch3_out_a), .ch3_out_b(ch3_out_b),
    .ch4_out_a(ch4_out_a), .ch4_out_b(ch4_out_b)
  );
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %0d seen %0d", nm, exp, seen);
    end
  endtask
  function automatic logic [31:0] ps(input realtime t);
    return 32'(int'(t * 1000.0));
  endfunction
  // one write cycle, strobe dropped on the following edge
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [8:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  // sync, then let dividers and source measurement settle
  task automatic sync_wait();
    wr(CHD_OFF_SYNC, 8'h01);
    repeat (60) @(posedge sys_clk);
  endtask
  // high time and period of one output, from a clean rising edge
  task automatic meas(input int sel, input logic [31:0] ehi, input logic [31:0] eper,
                      input string nm);
    realtime t0, t1, t2;
    wait (outs[sel] === 1'b0);
    wait (outs[sel] === 1'b1);
    t0 = $realtime;
    wait (outs[sel] === 1'b0);
    t1 = $realtime;
    wait (outs[sel] === 1'b1);
    t2 = $realtime;
    check({nm, " high"}, ps(t1 - t0), ehi);
    check({nm, " period"}, ps(t2 - t0), eper);
  endtask
  // lag of an output's rise behind the rise of divider 0
  task automatic lag(input int sel, input logic [31:0] exp, input string nm);
    realtime t0;
    wait (outs[0] === 1'b0);
    wait (outs[0] === 1'b1);
    t0 = $realtime;
    wait (outs[sel] === 1'b0);
    wait (outs[sel] === 1'b1);
    check(nm, ps($realtime - t0), exp);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // reset values, unmapped place, B outputs off until enabled
  task automatic t_reset();
    logic [8:0] regs [14] = '{9'h190, 9'h191, 9'h193, 9'h194, 9'h196, 9'h197,
      9'h199, 9'h19b, 9'h19c, 9'h19d, 9'h19e, 9'h1a0, 9'h1a1, 9'h1a2};
    logic [7:0] v;
    logic [6:0] held;
    foreach (regs[i]) begin
      rd(regs[i], v);
      check("reset value", v, 0);
    end
    // boot sync has run, so the sticky flag must read one
    rd(9'h1a6, v);
    check("synced flag", v[7:5], 3'h1);
    wr(9'h1ff, 8'hff);
    rd(9'h1ff, v);
    check("unmapped read", v, 0);
    wr(9'h190, 8'h5a);
    rd(9'h190, v);
    check("count readback", v, 8'h5a);
    wr(9'h190, 8'h00);
    repeat (6) begin
      @(posedge sys_clk);
      #1 check("b outputs off", {ch3_out_b, ch4_out_b}, 0);
    end
    meas(0, 4000, 8000, "default div0");
    wr(9'h1a4, 8'h03);
    repeat (6) begin
      @(posedge sys_clk);
      #1 check("b follows a", {ch3_out_b, ch4_out_b}, {ch3_out_a, ch4_out_a});
    end
    wr(9'h1a4, 8'h00);
    // clock enable low: every output must hold its level
    @(posedge sys_clk);
    ce <= 1'b0;
    #1 held = outs;
    repeat (4) begin
      @(posedge sys_clk);
      #1 check("ce freeze", outs, held);
    end
    @(posedge sys_clk);
    ce <= 1'b1;
    $display("test reset done");
  endtask
  // counts held until sync, uncorrected duty, corrected odd division
  task automatic t_count();
    wr(9'h192, 8'h01);
    wr(9'h190, 8'h21);
    meas(0, 4000, 8000, "before sync");
    sync_wait();
    meas(0, 8000, 20000, "odd off");
    wr(9'h190, 8'h31);
    sync_wait();
    meas(0, 8000, 24000, "even off");
    wr(9'h192, 8'h00);
    wr(9'h190, 8'h21);
    sync_wait();
    meas(0, 10000, 20000, "odd corrected");
    $display("test count done");
  endtask
  // coarse delay: plain code at its top value, start-high code with M
  task automatic t_phase();
    for (int d = 0; d < 3; d++) begin
      wr(9'(9'h190 + 3 * d), 8'h77);
    end
    wr(9'h191, 8'h00);
    wr(9'h194, 8'h0f);
    wr(9'h197, 8'h12);
    sync_wait();
    meas(1, 32000, 64000, "div1 counts");
    lag(1, 60000, "div1 delay");
    lag(2, 40000, "div2 delay");
    $display("test phase done");
  endtask
  // cascaded dividers 3 and 4 through all legal bypass settings
  task automatic t_cascade();
    logic [8:0] base [2][4] = '{'{9'h199, 9'h19b, 9'h19c, 9'h19d},
                                '{9'h19e, 9'h1a0, 9'h1a1, 9'h1a2}};
    int sel;
    src_hi = 3;
    src_lo = 3;
    for (int k = 0; k < 2; k++) begin
      sel = k ? 5 : 3;
      wr(base[k][0], 8'h00);
      wr(base[k][1], 8'h20);
      wr(base[k][2], 8'h00);
      wr(base[k][3], 8'h01);
      sync_wait();
      meas(sel, 8000, 32000, "two stages");
      // only the second stage may be bypassed alone
      wr(base[k][2], 8'h20);
      sync_wait();
      meas(sel, 4000, 8000, "second bypassed");
      wr(base[k][0], 8'h10);
      wr(base[k][3], 8'h00);
      sync_wait();
      meas(sel, 6000, 12000, "stage corrected");
      wr(base[k][2], 8'h30);
      wr(base[k][3], 8'h01);
      sync_wait();
      meas(sel, 12000, 24000, "both bypassed");
    end
    $display("test cascade done");
  endtask
  // bypassed divider 0 with an odd and an even source
  task automatic t_bypass();
    src_hi = 1;
    src_lo = 2;
    wr(9'h192, 8'h01);
    wr(9'h191, 8'h80);
    sync_wait();
    meas(0, 4000, 12000, "bypass odd off");
    wr(9'h192, 8'h00);
    sync_wait();
    meas(0, 6000, 12000, "bypass odd on");
    // a divide-by-five source, corrected: two and a half cycles high
    src_hi = 2;
    src_lo = 3;
    sync_wait();
    meas(0, 10000, 20000, "bypass five on");
    src_lo = 2;
    wr(9'h192, 8'h01);
    sync_wait();
    meas(0, 8000, 16000, "bypass even");
    $display("test bypass done");
  endtask
  // ----------------------------------------------------------------
  // verdict and main sequence
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    t_reset();
    t_count();
    t_phase();
    t_cascade();
    t_bypass();
    conclude();
  end
endmodule // tb_top
`default_nettype wire
